// [stf_pkg.sv]
// Constants, types and reset values shared by the serial transfer framer.
// Assumes an AXI4-Lite master with 16-bit addresses and 32-bit data.
package stf_pkg;
	// Register indices as printed; byte address is four times the index.
	localparam logic [15:0] IDX_CTRL = 16'h1028;
	localparam logic [15:0] IDX_STAT = 16'h1029;
	localparam logic [15:0] IDX_DATA = 16'h102A;
	localparam logic [15:0] ADDR_CTRL = {IDX_CTRL[13:0], 2'b00};
	localparam logic [15:0] ADDR_STAT = {IDX_STAT[13:0], 2'b00};
	localparam logic [15:0] ADDR_DATA = {IDX_DATA[13:0], 2'b00};
	// Control register fields.
	localparam int CTL_IRQ_EN = 7;
	localparam int CTL_SYS_EN = 6;
	localparam int CTL_OD = 5;
	localparam int CTL_MASTER_SELECT = 4;
	localparam int CTL_POL = 3;
	localparam int CTL_PHA = 2;
	localparam int CTL_RATE_HI = 1;
	localparam int CTL_RATE_LO = 0;
	// Status register fields.
	localparam int ST_TC = 7;
	localparam int ST_WRITE_COLLISION_FLAG = 6;
	localparam int ST_MODE_FAULT_FLAG = 4;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// Half-period masks for divide by 2, 4, 16 and 32.
	localparam logic [3:0] RMASK_0 = 4'h0;
	localparam logic [3:0] RMASK_1 = 4'h1;
	localparam logic [3:0] RMASK_2 = 4'h7;
	localparam logic [3:0] RMASK_3 = 4'hF;
	localparam logic [3:0] HALF_LAST = 4'hF;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Synchroniser bit positions; select idles high.
	localparam int IN_SCK = 0;
	localparam int IN_SS = 1;
	localparam int IN_MOSI = 2;
	localparam int IN_MISO = 3;
	localparam logic [3:0] SYNC_RST = 4'h2;

	typedef enum logic [2:0] {
		M_IDLE = 3'b001,
		M_WAIT = 3'b010,
		M_SHIFT = 3'b100
	} stf_mst_t;

	typedef struct packed {
		logic awvalid;
		logic [15:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [15:0] araddr;
		logic rready;
	} stf_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} stf_axi_rsp_t;

	typedef struct packed {
		logic sck;
		logic ss_n;
		logic mosi;
		logic miso;
	} stf_pins_in_t;

	typedef struct packed {
		logic sck_o;
		logic sck_oe;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
	} stf_pins_out_t;

	typedef struct packed {
		stf_axi_rsp_t rsp;
		stf_pins_out_t po;
		logic aw_got;
		logic w_got;
		logic [15:0] awaddr;
		logic [7:0] wdata;
		logic wbe;
		logic [7:0] ctrl;
		logic tc;
		logic write_collision_flag;
		logic tc_arm;
		logic write_collision_flag_arm;
		logic [7:0] sh;
		logic [7:0] rxbuf;
		logic lat;
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] flt;
		logic [3:0] div;
		stf_mst_t mst;
		logic [3:0] hc;
		logic sbusy;
		logic [2:0] bc;
	} stf_state_t;

	localparam stf_state_t STATE_RST = '{
		mst: M_IDLE,
		ctrl: CTRL_RST,
		s1: SYNC_RST,
		s2: SYNC_RST,
		s3: SYNC_RST,
		flt: SYNC_RST,
		default: '0
	};
endpackage : stf_pkg

// [stf_framer.sv]
// Serial peripheral transfer framer: master and slave, both phase formats,
// with an AXI4-Lite register slave. Pins arrive unsynchronised from the
// far party; the testbench resolves pin levels from the output enables.
`timescale 1ns/10ps

module stf_framer (
	input logic aclk,
	input logic aresetn,
	input stf_pkg::stf_axi_req_t axi_req,
	output stf_pkg::stf_axi_rsp_t axi_rsp,
	input stf_pkg::stf_pins_in_t pins_in,
	output stf_pkg::stf_pins_out_t pins_out
);
	import stf_pkg::*;

	stf_state_t r;
	stf_state_t n;
	logic [3:0] fn;
	logic [3:0] rmask;
	logic clock_polarity_select;
	logic clock_phase_select;
	logic m_en;
	logic s_en;
	logic tick;
	logic sedge;
	logic samp;
	logic wr_fire;
	logic rd_fire;
	logic wr_data;
	logic rd_data;
	logic rd_stat;
	logic dat_acc;
	logic busy_any;
	logic coll;
	logic start_ok;
	logic tc_set;
	logic write_collision_flag_set;

	assign axi_rsp = r.rsp;
	assign pins_out = r.po;

	assign clock_polarity_select = r.ctrl[CTL_POL];
	assign clock_phase_select = r.ctrl[CTL_PHA];
	assign m_en = r.ctrl[CTL_SYS_EN] & r.ctrl[CTL_MASTER_SELECT];
	assign s_en = r.ctrl[CTL_SYS_EN] & ~r.ctrl[CTL_MASTER_SELECT];

	// A pin change counts once the second and third stages agree.
	assign fn = (r.s2 & r.s3) | (r.flt & (r.s2 ^ r.s3));
	assign sedge = fn[IN_SCK] ^ r.flt[IN_SCK];
	// Phase 0 samples on the leading edge, phase 1 on the trailing one.
	assign samp = sedge & (fn[IN_SCK] ^ clock_polarity_select ^ clock_phase_select);

	always_comb begin
		case ({r.ctrl[CTL_RATE_HI], r.ctrl[CTL_RATE_LO]})
			2'h0: rmask = RMASK_0;
			2'h1: rmask = RMASK_1;
			2'h2: rmask = RMASK_2;
			default: rmask = RMASK_3;
		endcase
	end
	// The divider never stops, so a write lands anywhere in a period.
	assign tick = (r.div & rmask) == rmask;

	assign wr_fire = r.aw_got & r.w_got & ~r.rsp.bvalid;
	assign rd_fire = axi_req.arvalid & r.rsp.arready;
	assign wr_data = wr_fire & (r.awaddr == ADDR_DATA) & r.wbe;
	assign rd_data = rd_fire & (axi_req.araddr == ADDR_DATA);
	assign rd_stat = rd_fire & (axi_req.araddr == ADDR_STAT);
	assign dat_acc = (wr_fire & (r.awaddr == ADDR_DATA)) | rd_data;
	assign busy_any = (r.mst != M_IDLE) | r.sbusy;
	assign coll = wr_data & busy_any;
	assign start_ok = wr_data & ~busy_any & m_en;

	always_comb begin
		n = r;
		tc_set = 1'b0;
		write_collision_flag_set = 1'b0;
		n.s1 = {pins_in.miso, pins_in.mosi, pins_in.ss_n, pins_in.sck};
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.flt = fn;
		n.div = r.div + 4'h1;

		// Write address and data are taken independently, in any order.
		if (axi_req.awvalid && r.rsp.awready) begin
			n.aw_got = 1'b1;
			n.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && r.rsp.wready) begin
			n.w_got = 1'b1;
			n.wdata = axi_req.wdata[7:0];
			n.wbe = axi_req.wstrb[0];
		end
		if (r.rsp.bvalid && axi_req.bready) begin
			n.rsp.bvalid = 1'b0;
		end
		if (wr_fire) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.rsp.bvalid = 1'b1;
			n.rsp.bresp = RESP_OKAY;
			case (r.awaddr)
				ADDR_CTRL: begin
					if (r.wbe) begin
						n.ctrl = r.wdata;
					end
				end
				ADDR_STAT: begin
				end
				ADDR_DATA: begin
					if (coll) begin
						write_collision_flag_set = 1'b1;
					end else if (r.wbe) begin
						n.sh = r.wdata;
					end
				end
				default: n.rsp.bresp = RESP_SLVERR;
			endcase
		end
		n.rsp.awready = ~n.aw_got & ~n.rsp.bvalid;
		n.rsp.wready = ~n.w_got & ~n.rsp.bvalid;

		if (r.rsp.rvalid && axi_req.rready) begin
			n.rsp.rvalid = 1'b0;
		end
		if (rd_fire) begin
			n.rsp.rvalid = 1'b1;
			n.rsp.rresp = RESP_OKAY;
			case (axi_req.araddr)
				ADDR_CTRL: n.rsp.rdata = {24'h000000, r.ctrl};
				ADDR_STAT: begin
					n.rsp.rdata = 32'h00000000;
					n.rsp.rdata[ST_TC] = r.tc;
					n.rsp.rdata[ST_WRITE_COLLISION_FLAG] = r.write_collision_flag;
				end
				ADDR_DATA: n.rsp.rdata = {24'h000000, r.rxbuf};
				default: begin
					n.rsp.rdata = 32'h00000000;
					n.rsp.rresp = RESP_SLVERR;
				end
			endcase
		end
		n.rsp.arready = ~n.rsp.rvalid;

		// Master sequencer; the slave half never looks at the divider.
		case (r.mst)
			M_IDLE: begin
				if (start_ok) begin
					n.mst = M_WAIT;
				end
			end
			M_WAIT: begin
				if (!m_en) begin
					n.mst = M_IDLE;
				end else if (tick) begin
					n.mst = M_SHIFT;
					n.hc = 4'h0;
				end
			end
			M_SHIFT: begin
				if (!m_en) begin
					n.mst = M_IDLE;
				end else if (tick) begin
					if (r.hc == HALF_LAST) begin
						// Sixteen half periods make the eight bits.
						n.mst = M_IDLE;
						n.rxbuf = {r.sh[6:0], r.lat};
						tc_set = 1'b1;
					end else begin
						n.hc = r.hc + 4'h1;
						if (!r.hc[0]) begin
							n.lat = fn[IN_MISO];
						end else begin
							n.sh = {r.sh[6:0], r.lat};
						end
					end
				end
			end
			default: n.mst = M_IDLE;
		endcase

		// Slave half, driven only by the synchronised far clock and select.
		if (!s_en || fn[IN_SS]) begin
			n.sbusy = 1'b0;
			n.bc = 3'h0;
		end else begin
			if (!clock_phase_select && r.flt[IN_SS]) begin
				n.sbusy = 1'b1;
				n.bc = 3'h0;
			end
			if (sedge && (r.sbusy || clock_phase_select)) begin
				if (clock_phase_select) begin
					n.sbusy = 1'b1;
				end
				if (samp) begin
					n.lat = fn[IN_MOSI];
					if (r.bc == BIT_LAST) begin
						// The flag waits only on the synchroniser, so the
						// rate never moves it; polarity and phase together pick the sampling edge.
						n.rxbuf = {r.sh[6:0], fn[IN_MOSI]};
						tc_set = 1'b1;
						n.bc = 3'h0;
						if (clock_phase_select) begin
							n.sbusy = 1'b0;
						end
					end else begin
						n.bc = r.bc + 3'h1;
					end
				end else if (r.bc != 3'h0) begin
					n.sh = {r.sh[6:0], r.lat};
				end
			end
		end

		// Flags clear on status read with flag set, then a data access.
		if (rd_stat) begin
			n.tc_arm = r.tc;
			n.write_collision_flag_arm = r.write_collision_flag;
		end
		if (dat_acc) begin
			n.tc_arm = 1'b0;
			n.write_collision_flag_arm = 1'b0;
		end
		n.tc = (r.tc & ~(dat_acc & r.tc_arm)) | tc_set;
		n.write_collision_flag = (r.write_collision_flag & ~(dat_acc & r.write_collision_flag_arm)) | write_collision_flag_set;

		n.po.sck_oe = m_en;
		n.po.mosi_oe = m_en;
		n.po.miso_oe = s_en & ~fn[IN_SS];
		n.po.mosi_o = n.sh[7];
		n.po.miso_o = n.sh[7];
		n.po.sck_o = clock_polarity_select ^ ((n.mst == M_SHIFT) & (n.hc[0] ^ clock_phase_select));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= STATE_RST;
		end else begin
			r <= n;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_master_last;
		r.mst == M_SHIFT && r.hc == HALF_LAST && tick && m_en;
	endsequence

	sequence s_slave_last;
		s_en && !fn[IN_SS] && samp && r.bc == BIT_LAST &&
			(r.sbusy || clock_phase_select);
	endsequence

	sequence s_shift_entry;
		$rose(r.mst == M_SHIFT) && $stable(r.ctrl);
	endsequence

	property p_slave_start_pha0;
		s_en && !clock_phase_select && $stable(r.ctrl) && $fell(r.flt[IN_SS]) |-> r.sbusy;
	endproperty
	a_slave_start_pha0: assert property (p_slave_start_pha0)
		else $error("phase 0 slave did not start on select fall");

	property p_slave_start_pha1;
		s_en && clock_phase_select && $stable(r.ctrl) && !$past(r.sbusy) &&
			$changed(r.flt[IN_SCK]) && !r.flt[IN_SS] |-> r.sbusy;
	endproperty
	a_slave_start_pha1: assert property (p_slave_start_pha1)
		else $error("phase 1 slave did not start on first edge");

	property p_slave_abort;
		r.flt[IN_SS] |-> !r.sbusy && r.bc == 3'h0;
	endproperty
	a_slave_abort: assert property (p_slave_abort)
		else $error("select high left slave state running");

	property p_master_start_cause;
		$rose(r.mst == M_WAIT) |-> $past(start_ok);
	endproperty
	a_master_start_cause: assert property (p_master_start_cause)
		else $error("master left idle without a data write");

	property p_sck_first_pha0;
		s_shift_entry and !clock_phase_select |-> r.po.sck_o == clock_polarity_select && r.hc == 4'h0
			##1 (r.hc != 4'h0 || r.po.sck_o == clock_polarity_select);
	endproperty
	a_sck_first_pha0: assert property (p_sck_first_pha0)
		else $error("phase 0 clock not idle at first half");

	property p_sck_first_pha1;
		s_shift_entry and clock_phase_select |-> r.po.sck_o == !clock_polarity_select &&
			$past(r.po.sck_o) == clock_polarity_select;
	endproperty
	a_sck_first_pha1: assert property (p_sck_first_pha1)
		else $error("phase 1 clock did not open with active edge");

	property p_start_on_tick;
		$rose(r.mst == M_SHIFT) |-> $past(tick) && $past(r.mst) == M_WAIT;
	endproperty
	a_start_on_tick: assert property (p_start_on_tick)
		else $error("master start not aligned to divider tick");

	property p_wait_bounded;
		r.mst == M_WAIT && m_en && $stable(r.ctrl) |-> ##[0:15] tick;
	endproperty
	a_wait_bounded: assert property (p_wait_bounded)
		else $error("divider tick missing within a rate period");

	property p_sck_on_tick;
		m_en && $stable(r.ctrl) && r.ctrl == $past(r.ctrl, 2) &&
			$past(m_en) && $changed(r.po.sck_o) |-> $past(tick);
	endproperty
	a_sck_on_tick: assert property (p_sck_on_tick)
		else $error("clock edge not on a phase clock tick");

	property p_master_done;
		s_master_last |=> r.tc && r.mst == M_IDLE;
	endproperty
	a_master_done: assert property (p_master_done)
		else $error("master flag not set after eighth cycle");

	property p_pha1_last_half;
		r.mst == M_SHIFT && r.hc == HALF_LAST && clock_phase_select |-> r.po.sck_o == clock_polarity_select;
	endproperty
	a_pha1_last_half: assert property (p_pha1_last_half)
		else $error("phase 1 clock active in last half");

	property p_slave_done;
		s_slave_last |=> r.tc && r.bc == 3'h0;
	endproperty
	a_slave_done: assert property (p_slave_done)
		else $error("slave flag not set at eighth sample");

	property p_collision;
		coll |=> r.write_collision_flag;
	endproperty
	a_collision: assert property (p_collision)
		else $error("write during transfer did not flag collision");

	property p_collision_keeps;
		coll && r.mst == M_SHIFT && r.hc != HALF_LAST && m_en
			|=> r.mst == M_SHIFT;
	endproperty
	a_collision_keeps: assert property (p_collision_keeps)
		else $error("collision disturbed the running transfer");
endmodule : stf_framer

// [stf_far.sv]
// Behavioural far party of the serial framer: an external master that
// frames bytes to the device, and an external slave that answers it.
// Assumes the bench resolves clock and data pin levels from the output enables.
`timescale 1ns/10ps
module stf_far (
	input wire logic aclk,
	input wire logic dev_sck,
	input wire logic dev_mosi,
	input wire logic dev_miso,
	output logic sck,
	output logic ss_n,
	output logic mosi,
	output logic miso
);
	logic [7:0] sr;
	logic [7:0] srx;
	logic [7:0] mrx;

	initial begin
		sck = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
		sr = 8'h00;
		srx = 8'h00;
		mrx = 8'h00;
	end

	// Slave role, first format: the refill bit keeps a dead line changing.
	assign miso = sr[7];
	always @(posedge dev_sck) srx <= {srx[6:0], dev_mosi};
	always @(negedge dev_sck) sr <= {sr[6:0], ~sr[0]};

	task automatic load(input logic [7:0] b);
		sr = b;
	endtask : load

	// Master role; fewer than eight bits with keep low is an abort.
	task automatic frame(input logic [7:0] tx, input logic clock_phase_select,
		input int nb, input logic keep);
		ss_n <= 1'b0;
		repeat (6) @(posedge aclk);
		for (int i = 0; i < nb; i++) begin
			sck <= clock_phase_select;
			mosi <= tx[7 - i];
			repeat (6) @(posedge aclk);
			sck <= ~clock_phase_select;
			mrx[7 - i] = dev_miso;
			repeat (6) @(posedge aclk);
		end
		sck <= 1'b0;
		repeat (6) @(posedge aclk);
		mosi <= ~mosi;
		if (!keep) ss_n <= 1'b1;
		repeat (6) @(posedge aclk);
	endtask : frame

	task automatic release_sel;
		ss_n <= 1'b1;
		repeat (6) @(posedge aclk);
	endtask : release_sel
endmodule : stf_far

// [stf_framer_test.sv]
// Self-checking bench of the serial framer: registers, master and slave
// transfers, collisions and aborts. Assumes stf_pkg and stf_far.
`timescale 1ns/10ps
module stf_framer_test;
	import stf_pkg::*;
	logic aclk;
	logic aresetn;
	stf_axi_req_t req;
	stf_axi_rsp_t rsp;
	stf_pins_in_t pin;
	stf_pins_out_t pout;
	logic f_sck;
	logic f_ss_n;
	logic f_mosi;
	logic f_miso;
	logic sck_q = 1'b0;
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	int tog = 0;
	int gap = 0;
	int half = 0;

	stf_framer stf_framer_i (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
		.axi_rsp(rsp), .pins_in(pin), .pins_out(pout));
	stf_far stf_far_i (.aclk(aclk), .dev_sck(pout.sck_o),
		.dev_mosi(pout.mosi_o), .dev_miso(pout.miso_o), .sck(f_sck),
		.ss_n(f_ss_n), .mosi(f_mosi), .miso(f_miso));

	always_comb begin
		pin.sck = pout.sck_oe ? pout.sck_o : f_sck;
		pin.ss_n = f_ss_n;
		pin.mosi = pout.mosi_oe ? pout.mosi_o : f_mosi;
		pin.miso = pout.miso_oe ? pout.miso_o : f_miso;
	end

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	// Counts clock toggles and the spacing of the latest pair of them.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		gap <= gap + 1;
		sck_q <= pout.sck_o;
		if (pout.sck_o !== sck_q) begin
			tog <= tog + 1;
			half <= gap + 1;
			gap <= 0;
		end
		if (cyc == 30000) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [7:0] d,
		output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= {24'h000000, d};
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && rsp.awready === 1'b1) begin
				aw = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (!w && rsp.wready === 1'b1) begin
				w = 1'b1;
				req.wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (rsp.bvalid !== 1'b1);
		r = rsp.bresp;
		req.bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [31:0] d,
		output logic [1:0] r);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do @(posedge aclk); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		do @(posedge aclk); while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	task automatic wait_flag(output logic [7:0] st);
		logic [31:0] d;
		logic [1:0] r;
		st = 8'h00;
		while (st[7] !== 1'b1) begin
			rd(ADDR_STAT, d, r);
			st = d[7:0];
		end
	endtask : wait_flag

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] st;
		logic [7:0] c;
		int t0;
		req = '0;
		aresetn = 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(ADDR_CTRL, d, r);
		chk("ctrl reset", d, {24'h000000, CTRL_RST});
		rd(ADDR_STAT, d, r);
		chk("status reset", d, 32'h00000000);
		rd(16'h0004, d, r);
		chk("unmapped", {30'h00000000, r}, {30'h00000000, RESP_SLVERR});
		// Master: every rate code, both phases and both polarities.
		for (int k = 0; k < 4; k++) begin
			c = 8'h50 | 8'(k) | (k == 1 ? 8'h04 : 8'h00) |
				(k == 2 ? 8'h08 : 8'h00);
			wr(ADDR_CTRL, c, r);
			chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
			chk("pins driven", {30'h0, pout.sck_oe, pout.mosi_oe}, 32'h3);
			// A polarity change moves the idle clock; let that toggle count first.
			@(posedge aclk);
			stf_far_i.load(8'h3C);
			t0 = tog;
			wr(ADDR_DATA, 8'hA5, r);
			if (k == 3) wr(ADDR_DATA, 8'h11, r);
			wait_flag(st);
			chk("toggles", tog - t0, 16);
			chk("half", half, k < 2 ? 1 << k : 8 << (k - 2));
			chk("idle", {31'h0, pout.sck_o}, {31'h0, c[3]});
			chk("status", st, k == 3 ? 8'hC0 : 8'h80);
			rd(ADDR_DATA, d, r);
			if (k == 3) begin
				chk("rx", d, 8'h3C);
				chk("far rx", stf_far_i.srx, 8'hA5);
			end
			rd(ADDR_STAT, d, r);
			chk("cleared", d, 8'h00);
		end
		// Slave, first format, with rate bits set that must not matter.
		wr(ADDR_CTRL, 8'h43, r);
		wr(ADDR_DATA, 8'h5A, r);
		stf_far_i.frame(8'hC3, 1'b0, 8, 1'b1);
		rd(ADDR_STAT, d, r);
		chk("slave done", d, 8'h80);
		chk("far got", stf_far_i.mrx, 8'h5A);
		chk("miso oe", {31'h0, pout.miso_oe}, 32'h1);
		wr(ADDR_DATA, 8'h77, r);
		rd(ADDR_STAT, d, r);
		chk("late write", d, 8'h40);
		rd(ADDR_DATA, d, r);
		chk("slave rx", d, 8'hC3);
		stf_far_i.release_sel();
		// A three-bit frame is cut short; the next frame must be whole.
		stf_far_i.frame(8'hFF, 1'b0, 3, 1'b0);
		wr(ADDR_DATA, 8'h24, r);
		stf_far_i.frame(8'h81, 1'b0, 8, 1'b0);
		rd(ADDR_STAT, d, r);
		chk("after abort", d, 8'h80);
		rd(ADDR_DATA, d, r);
		chk("abort rx", d, 8'h81);
		chk("abort tx", stf_far_i.mrx, 8'h24);
		// Slave, second format.
		wr(ADDR_CTRL, 8'h44, r);
		wr(ADDR_DATA, 8'hE7, r);
		stf_far_i.frame(8'h18, 1'b1, 8, 1'b0);
		rd(ADDR_STAT, d, r);
		chk("phase1 done", d, 8'h80);
		rd(ADDR_DATA, d, r);
		chk("phase1 rx", d, 8'h18);
		chk("phase1 tx", stf_far_i.mrx, 8'hE7);
		print_verdict();
	end
endmodule : stf_framer_test
